// ===== hdl/gpa_map.vh
`ifndef GPA_MAP_VH
`define GPA_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GPA_OFF_CTRL 8'h00
`define GPA_OFF_INMAP 8'h04
`define GPA_OFF_STATUS 8'h08
`define GPA_OFF_HIST0 8'h0C
`define GPA_OFF_HIST1 8'h10
`define GPA_OFF_HIST2 8'h14
`define GPA_OFF_HIST3 8'h18
`define GPA_OFF_HIST4 8'h1C

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define GPA_CTRL_RRST_BIT 0
`define GPA_CTRL_PANEL_BIT 1
`define GPA_CTRL_RESET 2'h2
`define GPA_INMAP_RESET 8'h00
`define GPA_FUNC_FAULT_RESET 2'h1

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define GPA_ST_MODE_LSB 0
`define GPA_ST_LAMP_LSB 3
`define GPA_ST_SCREEN_LSB 9
`define GPA_ST_LATCH_BIT 14
`define GPA_ST_LINK_BIT 15

// ----------------------------------------------------------------------
// Screen codes
// ----------------------------------------------------------------------
`define GPA_SCR_MENU 3'h0
`define GPA_SCR_COMM_INIT 3'h1
`define GPA_SCR_COMM_LOST 3'h2
`define GPA_SCR_EVENT 3'h3
`define GPA_SCR_DATASAVE 3'h4
`define GPA_SCR_FAULT 3'h5

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define GPA_HIST_DEPTH 5
`define GPA_NUM_CFG_IN 4
`define GPA_NUM_PINS 11

`endif

// ===== hdl/gpa_panel.v
// How it works
// R1 - Off button selects off mode
// R2 - Off while running: immediate stop, off mode
// R3 - Not-in-auto lamp lit outside auto mode
// R4 - Shutdown lamp lights; starts inhibited while latched
// R5 - Lamp clears only on reset after correction
// R6 - Override: lamp lit, engine keeps running
// R7 - Warning lamp follows warning condition
// R8 - Remote start lamp follows remote request
// R9 - Auto lamp; auto soft-key from menus
// R10 - Manual lamp; manual soft-key from menus
// R11 - Pop-ups show, persist, dismiss restores screen
// R12 - Link loss forces three lamps off
// R13 - Reconnecting screen until link returns
// R14 - Mode keys work on comm screens
// R15 - Event screen shows remaining time
// R16 - Data save never blocks starting
// R17 - Keep five most recent fault codes
// R18 - Acknowledge after correction via off/switch
// R19 - Remote reset only in auto, enabled
// R20 - Remote reset only on mapped input
// R21 - Remote reset ignored while remote start
// R22 - Up/down clears fault; refaults reannounce
// R23 - Power-up in off mode
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"

module gpa_panel (
   input wire sys_clk,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire btnOff,
   input wire btnAuto,
   input wire btnManual,
   input wire btnUp,
   input wire btnDown,
   input wire btnDismiss,
   input wire switchOff,
   input wire [3:0] cfgIn,
   input wire linkUp,
   input wire shutdownCond,
   input wire shutdownOverridden,
   input wire warningCond,
   input wire remoteStartReq,
   input wire faultNew,
   input wire [15:0] faultCode,
   input wire eventActive,
   input wire [15:0] eventSecs,
   input wire dataSaveBusy,
   input wire engineRunning,
   output reg lampNotAuto,
   output reg lampShutdown,
   output reg lampWarning,
   output reg lampRemote,
   output reg lampAuto,
   output reg lampManual,
   output reg runCmd,
   output reg hotStop,
   output reg faultAck,
   output reg [2:0] screen,
   output reg [15:0] countdown,
   output reg [15:0] shownFault
);

   // -------------------------------------------------------------------
   // Mode states
   // -------------------------------------------------------------------
   localparam [2:0] MODE_OFF = 3'h1;
   localparam [2:0] MODE_AUTO = 3'h2;
   localparam [2:0] MODE_MAN = 3'h4;

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   // Three stages; a pin change counts only when stages two and three
   // agree, which also filters single-cycle glitches.
   // Pins idle low, so zero after reset gives no false edge.
   wire [10:0] pinRaw = {cfgIn, switchOff, btnDismiss, btnDown, btnUp,
      btnManual, btnAuto, btnOff};
   reg [10:0] sync1_q, sync2_q, sync3_q, pinStable_q, pinPrev_q;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_q <= 11'h000;
         sync2_q <= 11'h000;
         sync3_q <= 11'h000;
         pinStable_q <= 11'h000;
         pinPrev_q <= 11'h000;
      end else begin
         sync1_q <= pinRaw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pinStable_q <= (~(sync2_q ^ sync3_q) & sync2_q) |
            ((sync2_q ^ sync3_q) & pinStable_q);
         pinPrev_q <= pinStable_q;
      end
   end
   wire [10:0] pinRise = pinStable_q & ~pinPrev_q;
   wire offPress = pinRise[0];
   wire autoPress = pinRise[1];
   wire manPress = pinRise[2];
   wire upDownPress = pinRise[3] | pinRise[4];
   wire dismissPress = pinRise[5];
   wire switchToOff = pinRise[6];
   wire [3:0] cfgRise = pinRise[10:7];

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   reg [1:0] ctrl_q;
   reg [7:0] inMap_q;
   reg [2:0] mode_q, mode_d;
   reg latch_q;
   reg [2:0] prevScreen_q;
   reg linkSeen_q;
   reg eventPrev_q, savePrev_q, linkPrev_q;
   reg [15:0] hist_q [0:4];
   reg wrPend_q;
   reg [7:0] wrAddr_q;
   integer i;
   // Separate index so the clocked loop never shares the decode loop's
   integer j;

   function [31:0] readMux;
      input [7:0] a;
      begin
         case (a)
            `GPA_OFF_CTRL: readMux = {30'h00000000, ctrl_q};
            `GPA_OFF_INMAP: readMux = {24'h000000, inMap_q};
            `GPA_OFF_STATUS: readMux = {16'h0000, linkUp, latch_q,
               2'h0, screen, lampManual, lampAuto, lampRemote,
               lampWarning, lampShutdown, lampNotAuto, mode_q};
            `GPA_OFF_HIST0: readMux = {16'h0000, hist_q[0]};
            `GPA_OFF_HIST1: readMux = {16'h0000, hist_q[1]};
            `GPA_OFF_HIST2: readMux = {16'h0000, hist_q[2]};
            `GPA_OFF_HIST3: readMux = {16'h0000, hist_q[3]};
            `GPA_OFF_HIST4: readMux = {16'h0000, hist_q[4]};
            default: readMux = 32'h00000000;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------------
   // Zero wait states: read data is formed in the address phase and
   // registered so it stands for the whole data phase.
   // hsize is not decoded: every register is one whole word.
   wire addrPhase = hsel & hready & htrans[1];
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         ctrl_q <= `GPA_CTRL_RESET;
         inMap_q <= `GPA_INMAP_RESET;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_q <= addrPhase & hwrite;
         if (addrPhase) begin
            wrAddr_q <= haddr[7:0];
         end
         if (addrPhase & ~hwrite) begin
            hrdata <= readMux(haddr[7:0]);
         end
         if (wrPend_q) begin
            if (wrAddr_q == `GPA_OFF_CTRL) begin
               ctrl_q <= hwdata[1:0];
            end
            if (wrAddr_q == `GPA_OFF_INMAP) begin
               inMap_q <= hwdata[7:0];
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Fault acknowledge
   // -------------------------------------------------------------------
   wire panelFitted = ctrl_q[`GPA_CTRL_PANEL_BIT];
   reg [3:0] cfgMapped;
   always @* begin
      for (i = 0; i < `GPA_NUM_CFG_IN; i = i + 1) begin
         cfgMapped[i] = (inMap_q[2*i +: 2] == `GPA_FUNC_FAULT_RESET); // R20
      end
   end
   // Without a panel the harness switch is the only local acknowledge.
   wire localAck = panelFitted ? offPress : switchToOff; // R18
   // A remote reset with remote start still asserted would restart the
   // set straight into the fault, so it is refused.
   wire remoteAck = ctrl_q[`GPA_CTRL_RRST_BIT] & (mode_q == MODE_AUTO) &
      ~remoteStartReq & |(cfgRise & cfgMapped); // R19 R20 R21
   wire ackReq = localAck | remoteAck;
   wire ackTakes = ackReq & ~shutdownCond; // R18

   // -------------------------------------------------------------------
   // Mode machine
   // -------------------------------------------------------------------
   // Soft-keys are honoured on every operator and comm screen; only a
   // pop-up fault, event or data save owns the keys otherwise.
   wire keysLive = (screen == `GPA_SCR_MENU) |
      (screen == `GPA_SCR_COMM_INIT) |
      (screen == `GPA_SCR_COMM_LOST); // R14
   wire offReq = offPress | (~panelFitted & switchToOff);
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         MODE_OFF: begin
            if (autoPress & keysLive) begin
               mode_d = MODE_AUTO; // R9
            end else if (manPress & keysLive) begin
               mode_d = MODE_MAN; // R10
            end
         end
         MODE_AUTO: begin
            if (offReq) begin
               mode_d = MODE_OFF; // R1
            end else if (manPress & keysLive) begin
               mode_d = MODE_MAN; // R10
            end
         end
         MODE_MAN: begin
            if (offReq) begin
               mode_d = MODE_OFF; // R1
            end else if (autoPress & keysLive) begin
               mode_d = MODE_AUTO; // R9
            end
         end
         default: mode_d = MODE_OFF;
      endcase
   end

   // Starting is gated by the shutdown latch and live condition unless overridden; a data save in
   // progress deliberately has no say here.
   wire inhibit = (latch_q | shutdownCond) & ~shutdownOverridden; // R4 R6 R16
   wire wantRun = (mode_d == MODE_MAN) |
      ((mode_d == MODE_AUTO) & remoteStartReq);

   // Hot stop skips the cooldown; it is flagged only when the engine is
   // really turning and the mode actually leaves run.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_q <= MODE_OFF; // R23
         latch_q <= 1'b0;
         runCmd <= 1'b0;
         hotStop <= 1'b0;
         faultAck <= 1'b0;
      end else begin
         mode_q <= mode_d;
         runCmd <= wantRun & ~inhibit; // R4 R6 R16
         hotStop <= offReq & engineRunning & (mode_q != MODE_OFF); // R2
         faultAck <= ackTakes & latch_q;
         // A new shutdown wins over an acknowledge in the same cycle
         if (shutdownCond) begin
            latch_q <= 1'b1; // R4
         end else if (ackTakes) begin
            latch_q <= 1'b0; // R5
         end
      end
   end

   // -------------------------------------------------------------------
   // Lamps
   // -------------------------------------------------------------------
   // Lamps start from live inputs after reset; core-reported lamps are
   // dark until the link is up.
   // Override never darkens the shutdown lamp; it only frees runCmd.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         lampNotAuto <= 1'b1;
         lampShutdown <= 1'b0;
         lampWarning <= 1'b0;
         lampRemote <= 1'b0;
         lampAuto <= 1'b0;
         lampManual <= 1'b0;
      end else begin
         lampNotAuto <= (mode_d != MODE_AUTO); // R3 R23
         lampAuto <= (mode_d == MODE_AUTO); // R9
         lampManual <= (mode_d == MODE_MAN); // R10
         lampShutdown <= linkUp & (latch_q | shutdownCond); // R4 R6 R12 R13
         lampWarning <= linkUp & warningCond; // R7 R12 R13
         lampRemote <= linkUp & remoteStartReq; // R8 R12 R13
      end
   end

   // -------------------------------------------------------------------
   // Screens and pop-ups
   // -------------------------------------------------------------------
   wire eventRise = eventActive & ~eventPrev_q;
   wire eventFall = ~eventActive & eventPrev_q;
   wire saveRise = dataSaveBusy & ~savePrev_q;
   wire saveFall = ~dataSaveBusy & savePrev_q;
   wire showingPopup = (screen == `GPA_SCR_EVENT) |
      (screen == `GPA_SCR_DATASAVE) | (screen == `GPA_SCR_FAULT);
   wire expired = ((screen == `GPA_SCR_EVENT) & eventFall) |
      ((screen == `GPA_SCR_DATASAVE) & saveFall);

   // A pop-up replacing another keeps the screen saved by the first,
   // so dismiss always lands on a non-pop-up screen.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         screen <= `GPA_SCR_COMM_INIT;
         prevScreen_q <= `GPA_SCR_MENU;
         linkSeen_q <= 1'b0;
         linkPrev_q <= 1'b0;
         eventPrev_q <= 1'b0;
         savePrev_q <= 1'b0;
         countdown <= 16'h0000;
         shownFault <= 16'h0000;
      end else begin
         linkPrev_q <= linkUp;
         eventPrev_q <= eventActive;
         savePrev_q <= dataSaveBusy;
         countdown <= eventActive ? eventSecs : 16'h0000; // R15
         if (linkUp) begin
            linkSeen_q <= 1'b1;
         end
         if (!linkUp) begin
            screen <= linkSeen_q ? `GPA_SCR_COMM_LOST : `GPA_SCR_COMM_INIT; // R13
         end else if (!linkPrev_q) begin
            screen <= `GPA_SCR_MENU; // R13
         end else if (faultNew) begin
            // A fault seen again after acknowledge is announced anew
            screen <= `GPA_SCR_FAULT; // R11 R22
            shownFault <= faultCode;
            if (!showingPopup) begin
               prevScreen_q <= screen;
            end
         end else if (eventRise | saveRise) begin
            screen <= eventRise ? `GPA_SCR_EVENT : `GPA_SCR_DATASAVE; // R11 R15
            if (!showingPopup) begin
               prevScreen_q <= screen;
            end
         end else if (showingPopup & (dismissPress | offPress | expired)) begin
            screen <= prevScreen_q; // R11
         end else if ((screen == `GPA_SCR_FAULT) & (upDownPress | faultAck)) begin
            screen <= prevScreen_q; // R22
         end
      end
   end

   // -------------------------------------------------------------------
   // Fault history
   // -------------------------------------------------------------------
   // Newest entry in slot 0; the oldest falls off the end.
   // A repeated fault takes a new slot, so each of the last five onsets is kept.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         for (j = 0; j < `GPA_HIST_DEPTH; j = j + 1) begin
            hist_q[j] <= 16'h0000;
         end
      end else if (faultNew) begin
         hist_q[0] <= faultCode; // R17
         for (j = 1; j < `GPA_HIST_DEPTH; j = j + 1) begin
            hist_q[j] <= hist_q[j-1]; // R17
         end
      end
   end

endmodule // gpa_panel
`default_nettype wire

// ===== testbench/gpa_panel_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Lamp and command relations seen at the panel pins
// ------------------------------------------------------------
module gpa_panel_assertions (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic linkUp,
   input wire logic shutdownCond,
   input wire logic shutdownOverridden,
   input wire logic warningCond,
   input wire logic remoteStartReq,
   input wire logic eventActive,
   input wire logic [15:0] eventSecs,
   input wire logic lampNotAuto,
   input wire logic lampShutdown,
   input wire logic lampWarning,
   input wire logic lampRemote,
   input wire logic lampAuto,
   input wire logic lampManual,
   input wire logic runCmd,
   input wire logic hotStop,
   input wire logic faultAck,
   input wire logic [15:0] countdown
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_MODE_LAMPS: assert property (
      lampNotAuto == !lampAuto) else $error("Mode lamps disagree");
   AST_MANUAL_LAMP: assert property (
      lampManual |-> lampNotAuto && !lampAuto) else $error("Manual lamp");
   AST_LINK_DARK: assert property (
      !linkUp |=> !(lampShutdown || lampWarning || lampRemote))
      else $error("Lamps lit with link down");
   AST_WARN_FOLLOW: assert property (
      $past(rst_n) && linkUp |=> lampWarning == $past(warningCond))
      else $error("Warning lamp wrong");
   AST_REMOTE_FOLLOW: assert property (
      $past(rst_n) && linkUp |=> lampRemote == $past(remoteStartReq))
      else $error("Remote lamp wrong");
   AST_SHUT_LIGHT: assert property (
      $past(rst_n) && linkUp && shutdownCond |=> lampShutdown)
      else $error("Shutdown lamp dark");
   // Override is the only way past a live shutdown
   AST_NO_START: assert property (
      lampShutdown && shutdownCond && !shutdownOverridden |=> !runCmd)
      else $error("Run while shut down");
   AST_HOT_STOP: assert property (
      hotStop |-> lampNotAuto && !lampManual && !runCmd)
      else $error("Hot stop outside off");
   AST_ACK_CLEAN: assert property (
      faultAck |-> !$past(shutdownCond)) else $error("Ack while faulted");
   AST_COUNT: assert property (
      $past(rst_n) |-> countdown ==
      ($past(eventActive) ? $past(eventSecs) : 16'h0000))
      else $error("Countdown wrong");
endmodule // gpa_panel_assertions
`default_nettype wire

// ===== testbench/gpa_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Controller core stand-in
// ------------------------------------------------------------
module gpa_core_model (
   input wire logic sys_clk,
   input wire logic [3:0] setCore,
   input wire logic [15:0] setCode,
   input wire logic runCmd,
   input wire logic hotStop,
   output logic linkUp,
   output logic shutdownCond,
   output logic warningCond,
   output logic remoteStartReq,
   output logic faultNew,
   output logic [15:0] faultCode,
   output logic engineRunning
);
   always @(posedge sys_clk) begin
      linkUp <= setCore[3];
      shutdownCond <= setCore[2];
      warningCond <= setCore[1];
      remoteStartReq <= setCore[0];
      // One report per fault onset; code is junk while no shutdown is set
      faultNew <= setCore[2] & ~shutdownCond;
      faultCode <= setCore[2] ? setCode : ~setCode;
      engineRunning <= runCmd & ~hotStop;
   end
endmodule // gpa_core_model
`default_nettype wire

// ===== testbench/test_genset_panel_annunciator.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpa_map.vh"
module test_genset_panel_annunciator;
   logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [10:0] pins;
   logic [3:0] core;
   logic [15:0] code, eventSecs, countdown, shownFault, faultCode;
   logic linkUp, shutdownCond, ovr, warningCond, remoteStartReq, faultNew;
   logic eventActive, dataSave, engineRunning, lampNotAuto, lampShutdown;
   logic lampWarning, lampRemote, lampAuto, lampManual, runCmd, hotStop;
   logic faultAck, sawHot, sawAck, clrSaw;
   logic [2:0] screen;
   int n_fail, n_tests, i;
   // Core {link,shut,warn,remote}, lamps {shut,warn,remote}, screen
   logic [9:0] rows [7] = '{10'h200, 10'h290, 10'h248, 10'h2D8, 10'h0C2,
      10'h2D8, 10'h200};
   assign hready = hreadyout;
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   gpa_panel u_gpa_panel (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .btnOff(pins[0]),
      .btnAuto(pins[1]), .btnManual(pins[2]), .btnUp(pins[3]),
      .btnDown(pins[4]), .btnDismiss(pins[5]), .switchOff(pins[10]),
      .cfgIn(pins[9:6]), .linkUp(linkUp), .shutdownCond(shutdownCond),
      .shutdownOverridden(ovr), .warningCond(warningCond),
      .remoteStartReq(remoteStartReq), .faultNew(faultNew),
      .faultCode(faultCode), .eventActive(eventActive),
      .eventSecs(eventSecs), .dataSaveBusy(dataSave),
      .engineRunning(engineRunning), .lampNotAuto(lampNotAuto),
      .lampShutdown(lampShutdown), .lampWarning(lampWarning),
      .lampRemote(lampRemote), .lampAuto(lampAuto), .lampManual(lampManual),
      .runCmd(runCmd), .hotStop(hotStop), .faultAck(faultAck),
      .screen(screen), .countdown(countdown), .shownFault(shownFault));
   gpa_core_model u_gpa_core_model (.sys_clk(sys_clk), .setCore(core),
      .setCode(code), .runCmd(runCmd), .hotStop(hotStop), .linkUp(linkUp),
      .shutdownCond(shutdownCond), .warningCond(warningCond),
      .remoteStartReq(remoteStartReq), .faultNew(faultNew),
      .faultCode(faultCode), .engineRunning(engineRunning));
   // Pulses are one cycle wide, so latch them for later checks
   always @(posedge sys_clk) begin
      if (clrSaw) begin
         sawHot <= 1'b0;
         sawAck <= 1'b0;
      end else begin
         if (hotStop === 1'b1) sawHot <= 1'b1;
         if (faultAck === 1'b1) sawAck <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic results;
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (hready !== 1'b1 && k < 99);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge sys_clk); k++; end while (hready !== 1'b1 && k < 99);
      rd = hrdata;
      chk("hresp", 32'h0, hresp);
      if (k >= 99) begin n_fail++; results(); end
   endtask
   // Held long enough to clear the input synchronisers
   task automatic press(input int b);
      pins[b] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      pins[b] <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic clear_saw;
      clrSaw <= 1'b1;
      @(posedge sys_clk);
      clrSaw <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
      pins = 0; core = 0; code = 16'h0A5C; ovr = 0; eventActive = 0;
      eventSecs = 0; dataSave = 0; clrSaw = 1;
      n_fail = 0; n_tests = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      clrSaw <= 1'b0;
      @(posedge sys_clk);
      ahb(0, `GPA_OFF_CTRL, 0); chk("ctrl", {30'h0, `GPA_CTRL_RESET}, rd);
      ahb(0, `GPA_OFF_INMAP, 0); chk("inmap", 32'h0, rd);
      ahb(0, 8'h40, 0); chk("unmapped", 32'h0, rd);
      chk("offAtStart", 32'h1, {lampAuto, lampNotAuto});
      for (i = 0; i < 7; i++) begin
         core <= rows[i][9:6];
         repeat (4) @(posedge sys_clk);
         chk("lamps", rows[i][5:3], {lampShutdown, lampWarning, lampRemote});
         chk("screen", rows[i][2:0], screen);
      end
      core <= 4'h0;
      press(1); chk("autoNoLink", 32'h2, {lampAuto, lampNotAuto});
      core <= 4'h8;
      press(2); chk("manual", 32'h7, {lampManual, lampNotAuto, runCmd});
      clear_saw();
      press(0); chk("offStop", 32'h6, {sawHot, lampNotAuto, runCmd});
      ovr <= 1'b1;
      press(2);
      core <= 4'hC;
      repeat (4) @(posedge sys_clk);
      chk("override", 32'h3, {lampShutdown, runCmd});
      chk("popup", `GPA_SCR_FAULT, screen);
      chk("shown", code, shownFault);
      ahb(0, `GPA_OFF_HIST0, 0); chk("hist0", code, rd);
      press(3); chk("upClears", `GPA_SCR_MENU, screen);
      ovr <= 1'b0;
      clear_saw();
      press(0);
      press(2); chk("inhibit", 32'h4, {lampShutdown, sawAck, runCmd});
      core <= 4'h8;
      repeat (4) @(posedge sys_clk);
      chk("held", 32'h1, lampShutdown);
      press(0); chk("ack", 32'h1, {lampShutdown, sawAck});
      ahb(0, `GPA_OFF_STATUS, 0); chk("status", 32'h8009, rd);
      ahb(1, `GPA_OFF_CTRL, 32'h3);
      ahb(1, `GPA_OFF_INMAP, 32'h10);
      press(1);
      core <= 4'hC;
      repeat (4) @(posedge sys_clk);
      core <= 4'h9;
      clear_saw();
      press(8);
      core <= 4'h8;
      press(7); chk("noRemoteAck", 32'h2, {lampShutdown, sawAck});
      press(8); chk("remoteAck", 32'h1, {lampShutdown, sawAck});
      dataSave <= 1'b1;
      core <= 4'h9;
      repeat (8) @(posedge sys_clk);
      chk("saveRun", 32'h1, runCmd);
      dataSave <= 1'b0;
      core <= 4'h8;
      eventActive <= 1'b1;
      eventSecs <= 16'h003C;
      repeat (8) @(posedge sys_clk);
      chk("event", {`GPA_SCR_EVENT, 16'h003C}, {screen, countdown});
      press(5); chk("dismiss", `GPA_SCR_MENU, screen);
      // No panel fitted: off button still selects off, switch acknowledges
      ahb(1, `GPA_OFF_CTRL, 32'h0);
      code <= 16'h3C71;
      core <= 4'hC;
      repeat (4) @(posedge sys_clk);
      ahb(0, `GPA_OFF_HIST0, 0); chk("hist0b", 32'h3C71, rd);
      ahb(0, `GPA_OFF_HIST1, 0); chk("hist1", 32'h0A5C, rd);
      core <= 4'h8;
      clear_saw();
      press(0); chk("noPanelOff", 32'h5, {lampShutdown, sawAck, lampNotAuto});
      press(10); chk("switchAck", 32'h3, {lampShutdown, sawAck, lampNotAuto});
      results();
   end
endmodule // test_genset_panel_annunciator
bind gpa_panel gpa_panel_assertions u_gpa_panel_assertions (.sys_clk,
   .rst_n, .linkUp, .shutdownCond, .shutdownOverridden, .warningCond,
   .remoteStartReq, .eventActive, .eventSecs, .lampNotAuto, .lampShutdown,
   .lampWarning, .lampRemote, .lampAuto, .lampManual, .runCmd, .hotStop,
   .faultAck, .countdown);
`default_nettype wire
